//--- hw/pmbus_fault_limit_response_regs.sv
`timescale 1ns/10ps
module pmbus_fault_limit_response_regs
  import pmbus_limits_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ack,
  output logic cmd_refused,
  output logic [15:0] cmd_rdata,
  input wire logic busy,
  input wire logic [15:0] iout_meas,
  input wire logic [15:0] temp_meas,
  input wire logic [15:0] vin_meas,
  input wire logic [15:0] vout_meas,
  input wire logic vout_ov_pin,
  input wire logic vin_uv_pin,
  input wire logic run_pin,
  output logic output_enable,
  output logic ramp_active,
  output logic power_good
);

  logic [7:0] output_overvoltage_response;
  logic [15:0] overcurrent_fault_threshold;
  logic [7:0] overcurrent_response;
  logic [15:0] overcurrent_warning_threshold;
  logic [15:0] overtemp_fault_threshold;
  logic [7:0] overtemp_response;
  logic [15:0] temp_warning_threshold;
  logic [15:0] input_overvoltage_threshold;
  logic [15:0] power_good_assert_level;
  logic [15:0] power_good_deassert_level;
  logic [15:0] turn_on_delay;
  logic [15:0] output_rise_time;
  logic [15:0] summary_status_word;

  logic [2:0] pin_meta;
  logic [2:0] pin_mid;
  logic [2:0] pin_late;
  logic [2:0] pin_clean;
  logic vout_ov;
  logic vin_uv;
  logic run_request;

  logic wr;
  logic rd;
  logic wr_ok;
  logic known_code;
  logic clear_faults;
  logic cml_invalid;
  logic [15:0] next_rdata;

  logic oc_fault;
  logic oc_warn;
  logic ot_fault;
  logic ot_warn;
  logic vin_ov;
  logic [3:0] shut;
  logic [3:0] tripped;
  logic responder_clear;
  logic oc_warn_seen;
  logic ot_warn_seen;
  logic uv_seen;

  logic [$clog2(CYCLES_PER_MS)-1:0] div_count;
  logic ms_tick;
  logic [15:0] ms_count;
  seq_state_t seq_state;

  // ==========================================================
  // helpers
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic logic retry_ok(input logic [15:0] v);
    retry_ok = (v[RETRY_MSB:RETRY_LSB] == RETRY_NONE) || (v[RETRY_MSB:RETRY_LSB] == RETRY_ALWAYS);
  endfunction : retry_ok

  function automatic logic [7:0] merge_retry(input logic [7:0] old, input logic [15:0] v);
    merge_retry = (old & ~RESP_WRITE_MASK) | (v[7:0] & RESP_WRITE_MASK);
  endfunction : merge_retry

  // ==========================================================
  // pin synchronisers, change taken when stages two and three agree
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta <= 3'h0;
      pin_mid <= 3'h0;
      pin_late <= 3'h0;
      pin_clean <= 3'h0;
    end
    else
    begin
      pin_meta <= {run_pin, vin_uv_pin, vout_ov_pin};
      pin_mid <= pin_meta;
      pin_late <= pin_mid;
      for (int i = 0; i < 3; i++)
        if (pin_mid[i] == pin_late[i])
          pin_clean[i] <= pin_late[i];
    end
  end

  assign vout_ov = pin_clean[0];
  assign vin_uv = pin_clean[1];
  assign run_request = pin_clean[2];

  // ==========================================================
  // command decode and range checks
  assign wr = cmd_valid && cmd_write;
  assign rd = cmd_valid && !cmd_write;
  assign clear_faults = wr && (cmd_code == CODE_CLEAR_FAULTS);

  always_comb
  begin
    known_code = 1'b1;
    wr_ok = 1'b0;
    unique case (cmd_code)
      CODE_CLEAR_FAULTS: wr_ok = 1'b1;
      CODE_VOUT_OV_RESP: wr_ok = retry_ok(cmd_wdata);
      CODE_OC_RESP: wr_ok = retry_ok(cmd_wdata);
      CODE_OT_RESP: wr_ok = retry_ok(cmd_wdata);
      CODE_OC_FAULT_LIM:
        wr_ok = in_range(cmd_wdata, OC_FAULT_MIN, OC_FAULT_MAX)
          && (cmd_wdata > overcurrent_warning_threshold);
      CODE_OC_WARN_LIM:
        wr_ok = in_range(cmd_wdata, OC_WARN_MIN, OC_WARN_MAX)
          && (cmd_wdata < overcurrent_fault_threshold);
      CODE_OT_FAULT_LIM:
        wr_ok = in_range(cmd_wdata, OT_FAULT_MIN, OT_FAULT_MAX)
          && (cmd_wdata > temp_warning_threshold);
      CODE_OT_WARN_LIM:
        wr_ok = in_range(cmd_wdata, OT_WARN_MIN, OT_WARN_MAX)
          && (cmd_wdata < overtemp_fault_threshold);
      CODE_VIN_OV_LIM: wr_ok = in_range(cmd_wdata, VIN_OV_MIN, VIN_OV_MAX);
      CODE_VIN_OV_RESP: wr_ok = 1'b0;
      CODE_PG_ON:
        wr_ok = in_range(cmd_wdata, PG_ON_MIN, PG_ON_MAX)
          && (cmd_wdata >= power_good_deassert_level + PG_GAP);
      CODE_PG_OFF:
        wr_ok = in_range(cmd_wdata, PG_OFF_MIN, PG_OFF_MAX)
          && (cmd_wdata + PG_GAP <= power_good_assert_level);
      CODE_TURN_ON_DELAY: wr_ok = in_range(cmd_wdata, TURN_ON_DELAY_MIN, TURN_ON_DELAY_MAX);
      CODE_OUTPUT_RISE_TIME: wr_ok = in_range(cmd_wdata, OUTPUT_RISE_TIME_MIN, OUTPUT_RISE_TIME_MAX);
      CODE_STATUS_WORD: wr_ok = 1'b0;
      default: known_code = 1'b0;
    endcase
  end

  // ==========================================================
  // response bytes, only the retry field is writable
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      output_overvoltage_response <= VOUT_OV_RESP_RESET;
      overcurrent_response <= OC_RESP_RESET;
      overtemp_response <= OT_RESP_RESET;
    end
    else if (wr && wr_ok)
    begin
      if (cmd_code == CODE_VOUT_OV_RESP)
        output_overvoltage_response <= merge_retry(output_overvoltage_response, cmd_wdata);
      if (cmd_code == CODE_OC_RESP)
        overcurrent_response <= merge_retry(overcurrent_response, cmd_wdata);
      if (cmd_code == CODE_OT_RESP)
        overtemp_response <= merge_retry(overtemp_response, cmd_wdata);
    end
  end

  // ==========================================================
  // thresholds and timing settings
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      overcurrent_fault_threshold <= OC_FAULT_RESET;
      overcurrent_warning_threshold <= OC_WARN_RESET;
      overtemp_fault_threshold <= OT_FAULT_RESET;
      temp_warning_threshold <= OT_WARN_RESET;
      input_overvoltage_threshold <= VIN_OV_RESET;
      power_good_assert_level <= PG_ON_RESET;
      power_good_deassert_level <= PG_OFF_RESET;
      turn_on_delay <= TURN_ON_DELAY_RESET;
      output_rise_time <= OUTPUT_RISE_TIME_RESET;
    end
    else if (wr && wr_ok)
    begin
      unique case (cmd_code)
        CODE_OC_FAULT_LIM: overcurrent_fault_threshold <= cmd_wdata;
        CODE_OC_WARN_LIM: overcurrent_warning_threshold <= cmd_wdata;
        CODE_OT_FAULT_LIM: overtemp_fault_threshold <= cmd_wdata;
        CODE_OT_WARN_LIM: temp_warning_threshold <= cmd_wdata;
        CODE_VIN_OV_LIM: input_overvoltage_threshold <= cmd_wdata;
        CODE_PG_ON: power_good_assert_level <= cmd_wdata;
        CODE_PG_OFF: power_good_deassert_level <= cmd_wdata;
        CODE_TURN_ON_DELAY: turn_on_delay <= cmd_wdata;
        CODE_OUTPUT_RISE_TIME: output_rise_time <= cmd_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read data and answer strobes
  always_comb
  begin
    unique case (cmd_code)
      CODE_VOUT_OV_RESP: next_rdata = {8'h00, output_overvoltage_response};
      CODE_OC_FAULT_LIM: next_rdata = overcurrent_fault_threshold;
      CODE_OC_RESP: next_rdata = {8'h00, overcurrent_response};
      CODE_OC_WARN_LIM: next_rdata = overcurrent_warning_threshold;
      CODE_OT_FAULT_LIM: next_rdata = overtemp_fault_threshold;
      CODE_OT_RESP: next_rdata = {8'h00, overtemp_response};
      CODE_OT_WARN_LIM: next_rdata = temp_warning_threshold;
      CODE_VIN_OV_LIM: next_rdata = input_overvoltage_threshold;
      CODE_VIN_OV_RESP: next_rdata = {8'h00, VIN_OV_RESP_VALUE};
      CODE_PG_ON: next_rdata = power_good_assert_level;
      CODE_PG_OFF: next_rdata = power_good_deassert_level;
      CODE_TURN_ON_DELAY: next_rdata = turn_on_delay;
      CODE_OUTPUT_RISE_TIME: next_rdata = output_rise_time;
      CODE_STATUS_WORD: next_rdata = summary_status_word;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_ack <= 1'b0;
      cmd_refused <= 1'b0;
      cmd_rdata <= 16'h0000;
    end
    else
    begin
      cmd_ack <= cmd_valid;
      cmd_refused <= cmd_valid && (!known_code || (cmd_write && !wr_ok) || (rd && cmd_code == CODE_CLEAR_FAULTS));
      if (rd)
        cmd_rdata <= next_rdata;
    end
  end

  // sticky communication fault, set wins over clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cml_invalid <= 1'b0;
    else if (cmd_valid && (!known_code || (cmd_write && !wr_ok)))
      cml_invalid <= 1'b1;
    else if (clear_faults)
      cml_invalid <= 1'b0;
  end

  // ==========================================================
  // fault detection against stored thresholds, output overvoltage from the pin
  assign oc_fault = iout_meas > overcurrent_fault_threshold;
  assign oc_warn = iout_meas > overcurrent_warning_threshold;
  assign ot_fault = temp_meas > overtemp_fault_threshold;
  assign ot_warn = temp_meas > temp_warning_threshold;
  assign vin_ov = vin_meas > input_overvoltage_threshold;
  assign responder_clear = clear_faults || !run_request;

  fault_responder u_vout_ov (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fault(vout_ov),
    .retry_always(output_overvoltage_response[RETRY_LSB]),
    .auto_recover(1'b0),
    .clear(responder_clear),
    .shut(shut[0]),
    .tripped(tripped[0])
  );

  fault_responder u_oc (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fault(oc_fault),
    .retry_always(overcurrent_response[RETRY_LSB]),
    .auto_recover(1'b0),
    .clear(responder_clear),
    .shut(shut[1]),
    .tripped(tripped[1])
  );

  fault_responder u_ot (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fault(ot_fault),
    .retry_always(overtemp_response[RETRY_LSB]),
    .auto_recover(1'b0),
    .clear(responder_clear),
    .shut(shut[2]),
    .tripped(tripped[2])
  );

  fault_responder u_vin_ov (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .fault(vin_ov),
    .retry_always(1'b0),
    .auto_recover(1'b1),
    .clear(responder_clear),
    .shut(shut[3]),
    .tripped(tripped[3])
  );

  // sticky warnings and undervoltage, set wins over clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oc_warn_seen <= 1'b0;
      ot_warn_seen <= 1'b0;
      uv_seen <= 1'b0;
    end
    else
    begin
      oc_warn_seen <= oc_warn || (oc_warn_seen && !clear_faults);
      ot_warn_seen <= ot_warn || (ot_warn_seen && !clear_faults);
      uv_seen <= vin_uv || (uv_seen && !clear_faults);
    end
  end

  // ==========================================================
  // millisecond tick and turn-on sequence
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      div_count <= '0;
    else if (ms_tick)
      div_count <= '0;
    else
      div_count <= div_count + 1'b1;
  end

  assign ms_tick = (div_count == $bits(div_count)'(CYCLES_PER_MS - 1));

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seq_state <= SEQ_OFF;
      ms_count <= 16'h0000;
    end
    else if (!run_request || (|shut))
    begin
      seq_state <= SEQ_OFF;
      ms_count <= 16'h0000;
    end
    else
    begin
      unique case (seq_state)
        SEQ_OFF:
        begin
          seq_state <= SEQ_DELAY;
          ms_count <= 16'h0000;
        end
        SEQ_DELAY:
          if (ms_count >= turn_on_delay)
          begin
            seq_state <= SEQ_RISE;
            ms_count <= 16'h0000;
          end
          else if (ms_tick)
            ms_count <= ms_count + 16'h0001;
        SEQ_RISE:
          if (ms_count >= output_rise_time)
            seq_state <= SEQ_ON;
          else if (ms_tick)
            ms_count <= ms_count + 16'h0001;
        SEQ_ON: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      output_enable <= 1'b0;
      ramp_active <= 1'b0;
    end
    else
    begin
      output_enable <= run_request && !(|shut) && (seq_state == SEQ_RISE || seq_state == SEQ_ON);
      ramp_active <= run_request && !(|shut) && (seq_state == SEQ_RISE);
    end
  end

  // power good with hysteresis between the two levels
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      power_good <= 1'b0;
    else if (!output_enable || vout_meas < power_good_deassert_level)
      power_good <= 1'b0;
    else if (vout_meas >= power_good_assert_level)
      power_good <= 1'b1;
  end

  // ==========================================================
  // summary status word
  always_comb
  begin
    summary_status_word = 16'h0000;
    summary_status_word[SW_VOUT] = tripped[0];
    summary_status_word[SW_IOUT] = tripped[1] || oc_warn_seen;
    summary_status_word[SW_INPUT] = tripped[3] || uv_seen;
    summary_status_word[SW_PG_N] = !power_good;
    summary_status_word[SW_BUSY] = busy;
    summary_status_word[SW_OFF] = !output_enable;
    summary_status_word[SW_VOUT_OV] = tripped[0];
    summary_status_word[SW_IOUT_OC] = tripped[1];
    summary_status_word[SW_VIN_UV] = uv_seen;
    summary_status_word[SW_TEMP] = tripped[2] || ot_warn_seen;
    summary_status_word[SW_CML] = cml_invalid;
  end

endmodule : pmbus_fault_limit_response_regs

//--- hw/pmbus_limits_pkg.sv
package pmbus_limits_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CODE_VOUT_OV_RESP = 8'h41;
  localparam logic [7:0] CODE_OC_FAULT_LIM = 8'h46;
  localparam logic [7:0] CODE_OC_RESP = 8'h47;
  localparam logic [7:0] CODE_OC_WARN_LIM = 8'h4a;
  localparam logic [7:0] CODE_OT_FAULT_LIM = 8'h4f;
  localparam logic [7:0] CODE_OT_RESP = 8'h50;
  localparam logic [7:0] CODE_OT_WARN_LIM = 8'h51;
  localparam logic [7:0] CODE_VIN_OV_LIM = 8'h55;
  localparam logic [7:0] CODE_VIN_OV_RESP = 8'h56;
  localparam logic [7:0] CODE_PG_ON = 8'h5e;
  localparam logic [7:0] CODE_PG_OFF = 8'h5f;
  localparam logic [7:0] CODE_TURN_ON_DELAY = 8'h60;
  localparam logic [7:0] CODE_OUTPUT_RISE_TIME = 8'h61;
  localparam logic [7:0] CODE_STATUS_WORD = 8'h79;

  // ==========================================================
  // response byte fields
  localparam int RETRY_LSB = 3;
  localparam int RETRY_MSB = 5;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ALWAYS = 3'h7;
  localparam logic [7:0] RESP_WRITE_MASK = 8'h38;
  localparam logic [7:0] VOUT_OV_RESP_RESET = 8'hb8;
  localparam logic [7:0] OC_RESP_RESET = 8'hf8;
  localparam logic [7:0] OT_RESP_RESET = 8'hb8;
  localparam logic [7:0] VIN_OV_RESP_VALUE = 8'hc0;

  // ==========================================================
  // limits: amps, degrees C, volts x10, milliseconds
  localparam logic [15:0] OC_FAULT_MIN = 16'h0022;
  localparam logic [15:0] OC_FAULT_MAX = 16'h0064;
  localparam logic [15:0] OC_WARN_MIN = 16'h0019;
  localparam logic [15:0] OC_WARN_MAX = 16'h005a;
  localparam logic [15:0] OT_FAULT_MIN = 16'h0019;
  localparam logic [15:0] OT_FAULT_MAX = 16'h008c;
  localparam logic [15:0] OT_WARN_MIN = 16'h0019;
  localparam logic [15:0] OT_WARN_MAX = 16'h007d;
  localparam logic [15:0] VIN_OV_MIN = 16'h01e0;
  localparam logic [15:0] VIN_OV_MAX = 16'h0384;
  localparam logic [15:0] PG_ON_MIN = 16'h005c;
  localparam logic [15:0] PG_ON_MAX = 16'h0075;
  localparam logic [15:0] PG_OFF_MIN = 16'h004c;
  localparam logic [15:0] PG_OFF_MAX = 16'h0065;
  localparam logic [15:0] PG_GAP = 16'h0010;
  localparam logic [15:0] TURN_ON_DELAY_MIN = 16'h0000;
  localparam logic [15:0] TURN_ON_DELAY_MAX = 16'h01f4;
  localparam logic [15:0] OUTPUT_RISE_TIME_MIN = 16'h000f;
  localparam logic [15:0] OUTPUT_RISE_TIME_MAX = 16'h01f4;

  // ==========================================================
  // threshold reset values
  localparam logic [15:0] OC_FAULT_RESET = 16'h003c;
  localparam logic [15:0] OC_WARN_RESET = 16'h0032;
  localparam logic [15:0] OT_FAULT_RESET = 16'h007d;
  localparam logic [15:0] OT_WARN_RESET = 16'h006e;
  localparam logic [15:0] VIN_OV_RESET = 16'h0258;
  localparam logic [15:0] PG_ON_RESET = 16'h0064;
  localparam logic [15:0] PG_OFF_RESET = 16'h0054;
  localparam logic [15:0] TURN_ON_DELAY_RESET = 16'h0000;
  localparam logic [15:0] OUTPUT_RISE_TIME_RESET = 16'h000f;

  // ==========================================================
  // status word bits
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_PG_N = 11;
  localparam int SW_BUSY = 7;
  localparam int SW_OFF = 6;
  localparam int SW_VOUT_OV = 5;
  localparam int SW_IOUT_OC = 4;
  localparam int SW_VIN_UV = 3;
  localparam int SW_TEMP = 2;
  localparam int SW_CML = 1;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_RISE, SEQ_ON} seq_state_t;
  typedef enum logic [1:0] {RESP_RUN, RESP_HOLD, RESP_RETRY} resp_state_t;

endpackage : pmbus_limits_pkg

//--- hw/fault_responder.sv
`timescale 1ns/10ps
module fault_responder
  import pmbus_limits_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic fault,
  input wire logic retry_always,
  input wire logic auto_recover,
  input wire logic clear,
  output logic shut,
  output logic tripped
);

  resp_state_t state;

  // ==========================================================
  // shutdown state, no delay cycles
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= RESP_RUN;
    else
    begin
      unique case (state)
        RESP_RUN:
          if (fault)
            state <= (retry_always || auto_recover) ? RESP_RETRY : RESP_HOLD;
        RESP_RETRY:
          if (!fault)
            state <= RESP_RUN;
        RESP_HOLD:
          if (clear && !fault)
            state <= RESP_RUN;
      endcase
    end
  end

  assign shut = (state != RESP_RUN) || fault;

  // ==========================================================
  // sticky trip flag, set wins over clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      tripped <= 1'b0;
    else if (fault)
      tripped <= 1'b1;
    else if (clear)
      tripped <= 1'b0;
  end

endmodule : fault_responder

//--- test/pmbus_limits_checker_assertions.sv
`timescale 1ns/10ps
module pmbus_limits_checker
  import pmbus_limits_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_ack,
  input wire logic cmd_refused,
  input wire logic [15:0] cmd_rdata,
  input wire logic power_good,
  input wire logic output_enable
);
  // ====================
  // command port
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  wire logic wr = cmd_valid && cmd_write;
  wire logic rd = cmd_valid && !cmd_write;
  chk_ack_after_cmd:
    assert property (cmd_valid |=> cmd_ack) else $error("no ack");
  chk_retry_code_legal:
    assert property (wr && cmd_code inside {8'h41, 8'h47, 8'h50} && !(cmd_wdata[5:3] inside {3'h0, 3'h7})
      |=> cmd_refused) else $error("bad retry accepted");
  chk_oc_limit_range:
    assert property (wr && cmd_code == 8'h46 && (cmd_wdata < 16'h0022 || cmd_wdata > 16'h0064) |=> cmd_refused)
      else $error("oc limit accepted");
  chk_ot_limit_range:
    assert property (wr && cmd_code == 8'h4f && (cmd_wdata < 16'h0019 || cmd_wdata > 16'h008c) |=> cmd_refused)
      else $error("ot limit accepted");
  chk_vin_limit_range:
    assert property (wr && cmd_code == 8'h55 && (cmd_wdata < 16'h01e0 || cmd_wdata > 16'h0384) |=> cmd_refused)
      else $error("vin limit accepted");
  chk_delay_limit_gate:
    assert property (wr && cmd_code == 8'h60 |=> cmd_refused == ($past(cmd_wdata) > 16'h01f4))
      else $error("delay gate wrong");
  chk_vin_resp_fixed:
    assert property (rd && cmd_code == 8'h56 |=> cmd_rdata == 16'h00c0) else $error("vin response wrong");
  chk_status_spare_zero:
    assert property (rd && cmd_code == 8'h79 |=> (cmd_rdata & 16'h1701) == 16'h0000
      && cmd_rdata[11] == !$past(power_good)) else $error("status word wrong");
  cover property (wr ##1 cmd_refused);
  cover property (wr ##1 cmd_ack && !cmd_refused);
  cover property ($fell(output_enable));
endmodule : pmbus_limits_checker

//--- test/pmbus_host_model.sv
`timescale 1ns/10ps
module pmbus_host_model (
  input wire logic core_clk,
  input wire logic cmd_ack,
  input wire logic cmd_refused,
  input wire logic [15:0] cmd_rdata,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  // ====================
  // command issue
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // idle lines show the inverse of the last request
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic rf,
    output logic [15:0] rd);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge core_clk);
    #1;
    rf = cmd_ack ? cmd_refused : 1'bx;
    rd = cmd_rdata;
    cmd_valid = 1'b0;
    cmd_write = ~w;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask : xfer
endmodule : pmbus_host_model

//--- test/pmbus_fault_limit_response_regs_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module pmbus_fault_limit_response_regs_test;
  typedef struct {logic w; logic r; logic [7:0] c; logic [15:0] d;} row_t;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic busy = 1'b0;
  logic vout_ov_pin = 1'b0;
  logic vin_uv_pin = 1'b0;
  logic run_pin = 1'b0;
  logic [15:0] iout_meas = 16'h0000;
  logic [15:0] temp_meas = 16'h0000;
  logic [15:0] vin_meas = 16'h01f4;
  logic [15:0] vout_meas = 16'h0078;
  logic cmd_valid, cmd_write, cmd_ack, cmd_refused, output_enable, ramp_active, power_good, rf;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, rd;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  // reads carry the expected data, writes the data sent
  row_t rows [0:36] = '{
    '{0,0,8'h41,16'h00b8}, '{0,0,8'h47,16'h00f8}, '{0,0,8'h50,16'h00b8},
    '{0,0,8'h56,16'h00c0}, '{1,1,8'h56,16'h00c0}, '{1,0,8'h41,16'hff07},
    '{0,0,8'h41,16'h0080}, '{1,1,8'h41,16'h0010}, '{0,0,8'h41,16'h0080},
    '{1,0,8'h47,16'h0000}, '{0,0,8'h47,16'h00c0}, '{1,1,8'h50,16'h0028},
    '{1,1,8'h46,16'h0021}, '{1,1,8'h46,16'h0065}, '{1,1,8'h46,16'h0032},
    '{1,0,8'h46,16'h0064}, '{1,1,8'h4a,16'h0018}, '{1,0,8'h4a,16'h005a},
    '{1,1,8'h4f,16'h008d}, '{1,1,8'h4f,16'h006e}, '{1,0,8'h4f,16'h008c},
    '{1,1,8'h51,16'h007e}, '{1,0,8'h51,16'h0019}, '{1,1,8'h55,16'h01df},
    '{1,0,8'h55,16'h0384}, '{1,1,8'h5f,16'h0055}, '{1,1,8'h5e,16'h0076},
    '{1,0,8'h5e,16'h0075}, '{1,0,8'h5f,16'h0065}, '{0,0,8'h5f,16'h0065},
    '{1,1,8'h60,16'h01f5}, '{1,0,8'h60,16'h0000}, '{1,1,8'h61,16'h000e},
    '{1,1,8'h61,16'h01f5}, '{0,0,8'h61,16'h000f}, '{1,1,8'h79,16'h0000},
    '{0,1,8'h20,16'h0000}};
  pmbus_fault_limit_response_regs #(.CYCLES_PER_MS(10)) pmbus_fault_limit_response_regs_i (.core_clk, .reset_n,
    .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .cmd_ack, .cmd_refused, .cmd_rdata, .busy, .iout_meas,
    .temp_meas, .vin_meas, .vout_meas, .vout_ov_pin, .vin_uv_pin, .run_pin, .output_enable, .ramp_active,
    .power_good);
  pmbus_host_model pmbus_host_model_i (.core_clk, .cmd_ack, .cmd_refused, .cmd_rdata, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_wdata);
  // ====================
  // clock, timeout, helpers
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    pmbus_host_model_i.xfer(w, c, d, rf, rd);
  endtask : cmd
  task automatic wait_oe(input logic v, input int n);
    int k;
    k = 0;
    while (output_enable !== v && k < n)
    begin
      tick(1);
      k++;
    end
    `CHK("output_enable", v, output_enable)
  endtask : wait_oe
  task give_verdict;
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // ====================
  // sequence
  initial
  begin
    tick(3);
    reset_n = 1'b1;
    foreach (rows[i])
    begin
      cmd(rows[i].w, rows[i].c, rows[i].d);
      `CHK("refused", rows[i].r, rf)
      if (!rows[i].w)
        `CHK("rdata", rows[i].d, rd)
    end
    run_pin = 1'b1;
    wait_oe(1'b1, 400);
    `CHK("ramp_active", 1'b1, ramp_active)
    tick(130);
    `CHK("ramp_active", 1'b1, ramp_active)
    tick(40);
    `CHK("ramp_active", 1'b0, ramp_active)
    `CHK("power_good", 1'b1, power_good)
    iout_meas = 16'h0065;
    wait_oe(1'b0, 2);
    iout_meas = 16'h0000;
    busy = 1'b1;
    tick(400);
    `CHK("output_enable", 1'b0, output_enable)
    cmd(1'b0, 8'h79, 16'h0000);
    `CHK("status_word", 16'h48d2, rd)
    busy = 1'b0;
    cmd(1'b1, 8'h03, 16'h0000);
    wait_oe(1'b1, 400);
    cmd(1'b1, 8'h47, 16'h0038);
    iout_meas = 16'h0065;
    wait_oe(1'b0, 2);
    iout_meas = 16'h0000;
    wait_oe(1'b1, 400);
    vin_meas = 16'h0385;
    wait_oe(1'b0, 2);
    vin_meas = 16'h01f4;
    wait_oe(1'b1, 400);
    vout_ov_pin = 1'b1;
    wait_oe(1'b0, 8);
    vout_ov_pin = 1'b0;
    tick(300);
    `CHK("output_enable", 1'b0, output_enable)
    cmd(1'b0, 8'h79, 16'h0000);
    `CHK("status_word", 16'he870, rd)
    reset_n = 1'b0;
    tick(1);
    reset_n = 1'b1;
    cmd(1'b0, 8'h41, 16'h0000);
    `CHK("vout_ov_response", 16'h00b8, rd)
    give_verdict();
  end
endmodule : pmbus_fault_limit_response_regs_test
bind pmbus_fault_limit_response_regs pmbus_limits_checker pmbus_limits_checker_i (.core_clk, .reset_n, .cmd_valid,
  .cmd_write, .cmd_code, .cmd_wdata, .cmd_ack, .cmd_refused, .cmd_rdata, .power_good, .output_enable);
